// ---- verilog/pin_mux_params.svh ----
// constants for the four-pin function multiplexer
// assumes inclusion by the package and the mux module only
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH

// pin slots inside the four-bit pin vectors
`define PMX_P27           0
`define PMX_P30           1
`define PMX_P31           2
`define PMX_P33           3
`define PMX_PIN_COUNT     4

// timer-b output select field codes
`define PMX_TBSEL_TIMER_B_OUTPUT    2'h1
`define PMX_TBSEL_BAD     2'h2

// chip-select mode field codes
`define PMX_CS_OFF        2'h0
`define PMX_CS_INPUT      2'h1

// reset values of the registered pin controls and pad readback
`define PMX_RST_OUT       4'h0
`define PMX_RST_OE        4'h0
`define PMX_RST_PULLUP    4'h0
`define PMX_RST_PORT_IN   4'h0

// synchroniser depth on pin inputs
`define PMX_SYNC_STAGES   2

`endif

// ---- verilog/pin_mux_pkg.sv ----
// types shared by the pin function multiplexer
// assumes pin_mux_params.svh sits beside it
`include "pin_mux_params.svh"

package pin_mux_pkg;

  // function currently given to port 3 bit 3
  typedef enum logic [2:0] {
    F_PORT_IN,
    F_PORT_OUT,
    F_SDATA_IN,
    F_SDATA_OUT,
    F_CS_IN,
    F_CS_OUT,
    F_CMP_IN
  } p33_func_t;

  // registered state of the mux beyond its input synchroniser
  typedef struct packed {
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] pin_pullup;
    logic [3:0] port_in;
    logic       tmr_d_in;
    logic       sdata_in;
    logic       cs_in;
    logic       cmp_in;
    logic       cmp_route;
    logic       bad_sel;
    p33_func_t  p33_func;
  } mux_state_t;

  // synchroniser state
  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
  } sync_state_t;

endpackage

// ---- verilog/pin_sync.sv ----
// two-stage synchroniser for the pad input levels
// assumes pads are asynchronous to clk; only stage two is read outside
module pin_sync
  import pin_mux_pkg::*;
#(
  parameter int WIDTH = 4
)(
  input  wire logic             clk,      // system clock
  input  wire logic             reset_n,  // async reset, active low
  input  wire logic [WIDTH-1:0] pad_in,   // raw pad levels
  output logic      [WIDTH-1:0] pad_sync  // synchronised levels
);

  // the state struct is four bits per stage, so no other width fits
  if (WIDTH != 4)
  begin
    $error("pin_sync serves exactly four pins");
  end

  sync_state_t s_q;
  sync_state_t s_d;

  always_comb
  begin
    s_d      = s_q;
    s_d.meta = pad_in;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign pad_sync = s_q.sync;

endmodule

// ---- verilog/pin_mux.sv ----
// function multiplexer for port 2 bit 7 and port 3 bits 0, 1 and 3
// assumes control bits come from registers on clk; pad inputs are async
// Contract
// (RULE1) p2_7: select 0 gives port in/out by direction; 1 gives timer-d signal
// (RULE2) p2_7 input functions get pull-up when pull-up group 5 is set
// (RULE3) p3_0, p3_1, p3_3 input functions get pull-up when group 6 is set
// (RULE4) p3_1 drives timer-b output when field is 01 and usage conditions hold
// (RULE5) p3_1 otherwise is port input or output by direction
// (RULE6) software never writes 10 into the timer-b output select field
// (RULE7) p3_3 with data select 1 carries serial data, direction ignored
// (RULE8) p3_3 with both selects 0 and mode 01/10/11 is chip select
// (RULE9) serial data output is open-drain when open-drain bit 1, bidirectional 0
// (RULE10) chip-select output is open-drain when its open-drain bit is 1
// (RULE11) p3_3 port input with irq3 enable routes pin to comparator b3; the code also needs the handshake select bit at 0
// (RULE12) don't-care bits are ignored; no function selected means plain port
`include "pin_mux_params.svh"
module pin_mux
  import pin_mux_pkg::*;
(
  input  wire logic       clk,                      // system clock, 20 MHz
  input  wire logic       reset_n,                  // async reset, active low
  input  wire logic [3:0] pin_in,                   // pad levels p2_7,p3_0,p3_1,p3_3
  output logic      [3:0] pin_out,                  // pad output values
  output logic      [3:0] pin_oe,                   // pad drive enables, high drives
  output logic      [3:0] pin_pullup,               // pull-up enables
  input  wire logic [3:0] port_out_data,            // port output latch bits
  output logic      [3:0] port_in_data,             // synchronised pad readback
  input  wire logic       port2_bit7_direction,     // 1 output, 0 input
  input  wire logic       port3_bit0_direction,     // 1 output, 0 input
  input  wire logic       port3_bit1_direction,     // 1 output, 0 input
  input  wire logic       port3_bit3_direction,     // 1 output, 0 input
  input  wire logic       pullup_group5,            // pull-up enable for p2_7
  input  wire logic       pullup_group6,            // pull-up enable for p3_x
  input  wire logic       timer_d_ch1_d_pin_select, // p2_7 to timer d
  input  wire logic       timer_d_ch1_d_out,        // timer d output value
  input  wire logic       timer_d_ch1_d_oe,         // timer d wants to drive
  output logic            timer_d_ch1_d_signal,     // pin value to timer d
  input  wire logic       timer_a_out_pin_select,   // p3_0 to timer a
  input  wire logic       timer_a_out_enable,       // timer a output enabled
  input  wire logic       timer_a_out,              // timer a output value
  input  wire logic [1:0] timer_b_output_select,    // p3_1 timer b select field
  input  wire logic       timer_b_usage_ok,         // timer b output conditions met
  input  wire logic       timer_b_output,           // timer b output value
  output logic            timer_b_prohibited_sel,   // select field holds 10
  input  wire logic       serial_data_pin_select,   // p3_3 to serial data
  input  wire logic       serial_chipsel_pin_select,// 0 lets p3_3 be chip select
  input  wire logic       serial_data_out_en,       // serial data output control
  input  wire logic       serial_data_out,          // serial data value
  output logic            serial_unit_data_line,    // pin value to serial data
  input  wire logic [1:0] chip_select_mode_field,   // chip-select mode
  input  wire logic       serial_chipsel_out,       // chip-select output value
  output logic            serial_unit_chip_select,  // pin value to chip select
  input  wire logic       data_open_drain_bit,      // data open-drain option
  input  wire logic       chipsel_open_drain_bit,   // chip-select open-drain option
  input  wire logic       bidirectional_mode_bit,   // serial bidirectional mode
  input  wire logic       irq3_enable_bit,          // irq3 pin enable
  input  wire logic       handshake_select_bit,     // uart handshake on p3_3
  output logic            comparator_b3_input,      // pin value to comparator b3
  output logic            comparator_b3_select,     // comparator b3 uses the pin
  output p33_func_t       p3_3_function             // current p3_3 function
);

  mux_state_t s_q;
  mux_state_t s_d;
  logic [3:0] pin_s;

  pin_sync #(
    .WIDTH    (`PMX_PIN_COUNT)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .pad_in   (pin_in),
    .pad_sync (pin_s)
  );

  // returns {oe, out}; open-drain only sinks so a high releases the pad
  function automatic logic [1:0] drive_pin(input logic od, input logic val);
    if (od)
      return {~val, 1'b0};
    else
      return {1'b1, val};
  endfunction

  always_comb
  begin
    logic [1:0] drv;
    logic       tb_on;
    logic       p33_portlike;
    drv          = 2'h0;
    tb_on        = 1'b0;
    p33_portlike = 1'b0;
    s_d          = s_q;
    s_d.port_in  = pin_s;

    // (RULE1) timer d or port
    if (timer_d_ch1_d_pin_select)
      drv = timer_d_ch1_d_oe ? drive_pin(1'b0, timer_d_ch1_d_out) : 2'h0;
    else
      drv = port2_bit7_direction ? drive_pin(1'b0, port_out_data[`PMX_P27]) : 2'h0;
    {s_d.pin_oe[`PMX_P27], s_d.pin_out[`PMX_P27]} = drv;
    s_d.tmr_d_in = timer_d_ch1_d_pin_select & ~drv[1] & pin_s[`PMX_P27];

    // timer a output when enabled, plain port only when timer a is not selected
    if (timer_a_out_pin_select && timer_a_out_enable)
      drv = drive_pin(1'b0, timer_a_out);
    else if (!timer_a_out_pin_select && port3_bit0_direction)
      drv = drive_pin(1'b0, port_out_data[`PMX_P30]);
    else
      drv = 2'h0;
    {s_d.pin_oe[`PMX_P30], s_d.pin_out[`PMX_P30]} = drv;

    // (RULE4) timer b overrides direction
    tb_on = (timer_b_output_select == `PMX_TBSEL_TIMER_B_OUTPUT) && timer_b_usage_ok;
    if (tb_on)
      drv = drive_pin(1'b0, timer_b_output);
    // (RULE5) port fallback
    else
      drv = port3_bit1_direction ? drive_pin(1'b0, port_out_data[`PMX_P31]) : 2'h0;
    {s_d.pin_oe[`PMX_P31], s_d.pin_out[`PMX_P31]} = drv;
    // (RULE6) flag the forbidden code
    s_d.bad_sel = (timer_b_output_select == `PMX_TBSEL_BAD);

    // (RULE7) serial data has first claim on p3_3
    if (serial_data_pin_select)
      s_d.p33_func = serial_data_out_en ? F_SDATA_OUT : F_SDATA_IN;
    // (RULE8) chip select when both selects are 0
    else if (!serial_chipsel_pin_select && chip_select_mode_field != `PMX_CS_OFF)
      s_d.p33_func = (chip_select_mode_field == `PMX_CS_INPUT) ? F_CS_IN : F_CS_OUT;
    else
    begin
      p33_portlike = 1'b1;
      // (RULE11) comparator route needs port input and no handshake
      if (!port3_bit3_direction && !handshake_select_bit && irq3_enable_bit)
        s_d.p33_func = F_CMP_IN;
      // (RULE12) plain port fallback
      else
        s_d.p33_func = port3_bit3_direction ? F_PORT_OUT : F_PORT_IN;
    end

    unique case (s_d.p33_func)
      F_SDATA_OUT:
        // (RULE9) open-drain only in standard mode
        drv = drive_pin(data_open_drain_bit & ~bidirectional_mode_bit, serial_data_out);
      F_CS_OUT:
        // (RULE10) chip-select open-drain
        drv = drive_pin(chipsel_open_drain_bit, serial_chipsel_out);
      F_PORT_OUT:
        drv = drive_pin(1'b0, port_out_data[`PMX_P33]);
      F_PORT_IN, F_SDATA_IN, F_CS_IN, F_CMP_IN:
        drv = 2'h0;
    endcase
    {s_d.pin_oe[`PMX_P33], s_d.pin_out[`PMX_P33]} = drv;

    s_d.sdata_in  = (s_d.p33_func == F_SDATA_IN) & pin_s[`PMX_P33];
    s_d.cs_in     = (s_d.p33_func == F_CS_IN) & pin_s[`PMX_P33];
    s_d.cmp_route = p33_portlike & (s_d.p33_func == F_CMP_IN);
    s_d.cmp_in    = s_d.cmp_route & pin_s[`PMX_P33];

    // (RULE2) group 5 pull-up on undriven p2_7
    s_d.pin_pullup[`PMX_P27] = pullup_group5 & ~s_d.pin_oe[`PMX_P27];
    // (RULE3) group 6 pull-ups; open-drain high-release is an output, not input
    s_d.pin_pullup[`PMX_P30] = pullup_group6 & ~s_d.pin_oe[`PMX_P30]
                               & ~(timer_a_out_pin_select & timer_a_out_enable);
    s_d.pin_pullup[`PMX_P31] = pullup_group6 & ~s_d.pin_oe[`PMX_P31] & ~tb_on;
    s_d.pin_pullup[`PMX_P33] = pullup_group6 & ~s_d.pin_oe[`PMX_P33]
                               & (s_d.p33_func != F_SDATA_OUT)
                               & (s_d.p33_func != F_CS_OUT);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q            <= '0;
      s_q.pin_out    <= `PMX_RST_OUT;
      s_q.pin_oe     <= `PMX_RST_OE;
      s_q.pin_pullup <= `PMX_RST_PULLUP;
      s_q.port_in    <= `PMX_RST_PORT_IN;
      s_q.p33_func   <= F_PORT_IN;
    end
    else
      s_q <= s_d;
  end

  assign pin_out                 = s_q.pin_out;
  assign pin_oe                  = s_q.pin_oe;
  assign pin_pullup              = s_q.pin_pullup;
  assign port_in_data            = s_q.port_in;
  assign timer_d_ch1_d_signal    = s_q.tmr_d_in;
  assign timer_b_prohibited_sel  = s_q.bad_sel;
  assign serial_unit_data_line   = s_q.sdata_in;
  assign serial_unit_chip_select = s_q.cs_in;
  assign comparator_b3_input     = s_q.cmp_in;
  assign comparator_b3_select    = s_q.cmp_route;
  assign p3_3_function           = s_q.p33_func;

  property p_p27_port;  // RULE1
    @(posedge clk) disable iff (!reset_n)
    (!timer_d_ch1_d_pin_select && port2_bit7_direction)
      |=> pin_oe[`PMX_P27] && pin_out[`PMX_P27] == $past(port_out_data[`PMX_P27]);
  endproperty
  a_p27_port: assert property (p_p27_port) else $error("p2_7 port output wrong");

  property p_pu5;  // RULE2
    @(posedge clk) disable iff (!reset_n)
    (!timer_d_ch1_d_pin_select && !port2_bit7_direction && pullup_group5)
      |=> pin_pullup[`PMX_P27] && !pin_oe[`PMX_P27];
  endproperty
  a_pu5: assert property (p_pu5) else $error("p2_7 pull-up missing");

  property p_pu_exclusive;  // RULE3
    @(posedge clk) disable iff (!reset_n)
    (pin_pullup & pin_oe) == 4'h0;
  endproperty
  a_pu_exclusive: assert property (p_pu_exclusive) else $error("pull-up on driven pin");

  property p_timer_b_output;  // RULE4
    @(posedge clk) disable iff (!reset_n)
    (timer_b_output_select == `PMX_TBSEL_TIMER_B_OUTPUT && timer_b_usage_ok)
      |=> pin_oe[`PMX_P31] && pin_out[`PMX_P31] == $past(timer_b_output);
  endproperty
  a_timer_b_output: assert property (p_timer_b_output) else $error("timer b output not driven");

  property p_tb_port_in;  // RULE5
    @(posedge clk) disable iff (!reset_n)
    (!(timer_b_output_select == `PMX_TBSEL_TIMER_B_OUTPUT && timer_b_usage_ok)
      && !port3_bit1_direction) |=> !pin_oe[`PMX_P31];
  endproperty
  a_tb_port_in: assert property (p_tb_port_in) else $error("p3_1 input driven");

  property p_bad_sel;  // RULE6
    @(posedge clk) disable iff (!reset_n)
    $rose(timer_b_prohibited_sel) |-> $past(timer_b_output_select) == `PMX_TBSEL_BAD;
  endproperty
  a_bad_sel: assert property (p_bad_sel) else $error("prohibited flag without cause");

  property p_sdata;  // RULE7
    @(posedge clk) disable iff (!reset_n)
    (serial_data_pin_select && serial_data_out_en && !data_open_drain_bit)
      |=> pin_oe[`PMX_P33] && pin_out[`PMX_P33] == $past(serial_data_out);
  endproperty
  a_sdata: assert property (p_sdata) else $error("serial data not driven");

  property p_cs_in;  // RULE8
    @(posedge clk) disable iff (!reset_n)
    (!serial_data_pin_select && !serial_chipsel_pin_select
      && chip_select_mode_field == `PMX_CS_INPUT)
      |=> p3_3_function == F_CS_IN && !pin_oe[`PMX_P33];
  endproperty
  a_cs_in: assert property (p_cs_in) else $error("chip-select input not selected");

  property p_sdata_od;  // RULE9
    @(posedge clk) disable iff (!reset_n)
    (serial_data_pin_select && serial_data_out_en && data_open_drain_bit
      && !bidirectional_mode_bit && serial_data_out) |=> !pin_oe[`PMX_P33];
  endproperty
  a_sdata_od: assert property (p_sdata_od) else $error("open-drain data drove high");

  property p_cs_od;  // RULE10
    @(posedge clk) disable iff (!reset_n)
    (!serial_data_pin_select && !serial_chipsel_pin_select
      && chip_select_mode_field[1] && chipsel_open_drain_bit && serial_chipsel_out)
      |=> !pin_oe[`PMX_P33];
  endproperty
  a_cs_od: assert property (p_cs_od) else $error("open-drain chip select drove high");

  property p_cmp;  // RULE11
    @(posedge clk) disable iff (!reset_n)
    (!port3_bit3_direction && !serial_data_pin_select && serial_chipsel_pin_select
      && !handshake_select_bit && irq3_enable_bit)
      |=> comparator_b3_select && !pin_oe[`PMX_P33];
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator route missing");

  property p_p33_port;  // RULE12
    @(posedge clk) disable iff (!reset_n)
    (!serial_data_pin_select && serial_chipsel_pin_select && port3_bit3_direction)
      |=> pin_oe[`PMX_P33] && pin_out[`PMX_P33] == $past(port_out_data[`PMX_P33]);
  endproperty
  a_p33_port: assert property (p_p33_port) else $error("p3_3 port output wrong");

endmodule

// ---- bench/pad_board.sv ----
// board side of the four multiplexed pads: resolves each pad level
// assumes the bench sets ext_en only on pads that the mux leaves undriven
module pad_board (
  input  wire logic       clk,        // system clock
  input  wire logic [3:0] pin_out,    // mux output values
  input  wire logic [3:0] pin_oe,     // mux drive enables
  input  wire logic [3:0] pin_pullup, // mux pull-up enables
  input  wire logic [3:0] ext_en,     // board drives the pad
  input  wire logic [3:0] ext_val,    // board level
  output logic      [3:0] pad         // resolved pad level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] float_q = 4'h0;
  // a floating pad wanders every cycle so a stale level is never read as valid
  always @(posedge clk)
    float_q <= ~float_q;
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      pad[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
               pin_pullup[i] ? 1'b1 : float_q[i];
  end
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the four-pin function multiplexer
// assumes pad_board closes the loop from pad drivers back to pin_in
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pin_mux_pkg::*;
  // control word nibbles, high to low: direction, port data,
  // {pug5,pug6,irq3,hs}, {tdsel,tdout,tdoe,tbok}, {tasel,taen,taout,tbout},
  // {tbsel[1:0],csmode[1:0]}, {dsel,cssel,den,dout}, {sod,csod,bidirectional_mode_bit,cso}
  typedef struct packed {
    logic [31:0] c;
    logic [3:0]  oe;
    logic [3:0]  out;
    logic [3:0]  pu;
    p33_func_t   f;
  } row_t;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [31:0] ctl = 32'h0;
  logic [3:0]  ext_en = 4'h0;
  logic [3:0]  ext_val = 4'h0;
  logic [3:0]  pad, pin_out, pin_oe, pin_pullup, port_in_data;
  logic        td_sig, tb_bad, sd_line, cs_line, cmp_in, cmp_sel;
  p33_func_t   func;
  int          miscompares = 0;
  int          tests_run = 0;
  int          cycles = 0;
  // no row ever writes 10 into the timer-b select field
  row_t rows [21] = '{
    '{32'h00C00040, 4'h0, 4'h0, 4'hF, F_PORT_IN},
    '{32'hFAC00040, 4'hF, 4'hA, 4'h0, F_PORT_OUT},
    '{32'h000E0040, 4'h1, 4'h1, 4'h0, F_PORT_IN},
    '{32'h10880040, 4'h0, 4'h0, 4'h1, F_PORT_IN},
    '{32'h0000E040, 4'h2, 4'h2, 4'h0, F_PORT_IN},
    '{32'h22408040, 4'h0, 4'h0, 4'hE, F_PORT_IN},
    '{32'h00011440, 4'h4, 4'h4, 4'h0, F_PORT_IN},
    '{32'h40001440, 4'h4, 4'h0, 4'h0, F_PORT_IN},
    '{32'h00411C40, 4'h0, 4'h0, 4'hE, F_PORT_IN},
    '{32'h000001B0, 4'h8, 4'h8, 4'h0, F_SDATA_OUT},
    '{32'h804000F8, 4'h0, 4'h0, 4'h6, F_SDATA_OUT},
    '{32'h000000FA, 4'h8, 4'h8, 4'h0, F_SDATA_OUT},
    '{32'h80400080, 4'h0, 4'h0, 4'hE, F_SDATA_IN},
    '{32'h80400100, 4'h0, 4'h0, 4'hE, F_CS_IN},
    '{32'h00000201, 4'h8, 4'h8, 4'h0, F_CS_OUT},
    '{32'h00400305, 4'h0, 4'h0, 4'h6, F_CS_OUT},
    '{32'h00000304, 4'h8, 4'h0, 4'h0, F_CS_OUT},
    '{32'h88000240, 4'h8, 4'h8, 4'h0, F_PORT_OUT},
    '{32'h00600040, 4'h0, 4'h0, 4'hE, F_CMP_IN},
    '{32'h00700040, 4'h0, 4'h0, 4'hE, F_PORT_IN},
    '{32'h80200040, 4'h8, 4'h0, 4'h0, F_PORT_OUT}
  };

  always #25 clk = ~clk;

  pad_board board (
    .clk        (clk),
    .pin_out    (pin_out),
    .pin_oe     (pin_oe),
    .pin_pullup (pin_pullup),
    .ext_en     (ext_en),
    .ext_val    (ext_val),
    .pad        (pad)
  );

  pin_mux dut (
    .clk                       (clk),
    .reset_n                   (reset_n),
    .pin_in                    (pad),
    .pin_out                   (pin_out),
    .pin_oe                    (pin_oe),
    .pin_pullup                (pin_pullup),
    .port_out_data             (ctl[27:24]),
    .port_in_data              (port_in_data),
    .port2_bit7_direction      (ctl[28]),
    .port3_bit0_direction      (ctl[29]),
    .port3_bit1_direction      (ctl[30]),
    .port3_bit3_direction      (ctl[31]),
    .pullup_group5             (ctl[23]),
    .pullup_group6             (ctl[22]),
    .timer_d_ch1_d_pin_select  (ctl[19]),
    .timer_d_ch1_d_out         (ctl[18]),
    .timer_d_ch1_d_oe          (ctl[17]),
    .timer_d_ch1_d_signal      (td_sig),
    .timer_a_out_pin_select    (ctl[15]),
    .timer_a_out_enable        (ctl[14]),
    .timer_a_out               (ctl[13]),
    .timer_b_output_select     (ctl[11:10]),
    .timer_b_usage_ok          (ctl[16]),
    .timer_b_output            (ctl[12]),
    .timer_b_prohibited_sel    (tb_bad),
    .serial_data_pin_select    (ctl[7]),
    .serial_chipsel_pin_select (ctl[6]),
    .serial_data_out_en        (ctl[5]),
    .serial_data_out           (ctl[4]),
    .serial_unit_data_line     (sd_line),
    .chip_select_mode_field    (ctl[9:8]),
    .serial_chipsel_out        (ctl[0]),
    .serial_unit_chip_select   (cs_line),
    .data_open_drain_bit       (ctl[3]),
    .chipsel_open_drain_bit    (ctl[2]),
    .bidirectional_mode_bit    (ctl[1]),
    .irq3_enable_bit           (ctl[21]),
    .handshake_select_bit      (ctl[20]),
    .comparator_b3_input       (cmp_in),
    .comparator_b3_select      (cmp_sel),
    .p3_3_function             (func)
  );

  task automatic test_done();
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // controls land on a rising edge; n edges later sample at the falling edge
  task automatic drive(input logic [31:0] c, input logic [3:0] ee, input logic [3:0] ev,
                       input int n);
    @(posedge clk);
    ctl <= c;
    ext_en <= ee;
    ext_val <= ev;
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // whole run is under a hundred cycles; this ceiling only catches a hang
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      test_done();
    end
  end

  initial
  begin
    repeat (11) @(posedge clk);
    @(negedge clk);
    check("rst_oe", 8'(pin_oe), 8'h00);
    check("rst_pu", 8'(pin_pullup), 8'h00);
    check("rst_func", 8'(func), 8'(F_PORT_IN));
    @(posedge clk);
    reset_n <= 1'b1;
    foreach (rows[i])
    begin
      drive(rows[i].c, 4'h0, 4'h0, 1);
      check("pin_oe", 8'(pin_oe), 8'(rows[i].oe));
      check("pin_out", 8'(pin_out & pin_oe), 8'(rows[i].out));
      check("pin_pullup", 8'(pin_pullup), 8'(rows[i].pu));
      check("p33_func", 8'(func), 8'(rows[i].f));
      check("cmp_sel", 8'(cmp_sel), 8'(rows[i].f == F_CMP_IN));
      check("tb_flag", 8'(tb_bad), 8'h00);
    end
    // serial data input follows the pad exactly three edges later
    drive(32'h80400080, 4'h8, 4'h0, 5);
    @(posedge clk);
    ext_val <= 4'h8;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("sdata_early", 8'(sd_line), 8'h00);
    @(posedge clk);
    @(negedge clk);
    check("sdata", 8'(sd_line), 8'h01);
    check("port_in3", 8'(port_in_data[3]), 8'h01);
    check("cmp_idle", 8'(cmp_in), 8'h00);
    // comparator sees the pad once routed
    drive(32'h00600040, 4'h8, 4'h8, 5);
    check("cmp_in", 8'(cmp_in), 8'h01);
    check("sdata_off", 8'(sd_line), 8'h00);
    drive(32'h80400100, 4'h8, 4'h8, 5);
    check("cs_in", 8'(cs_line), 8'h01);
    // timer d input ignores the direction bit
    drive(32'h10880040, 4'h1, 4'h1, 5);
    check("tmr_d_in", 8'(td_sig), 8'h01);
    // undriven inputs read high through the pull-ups
    drive(32'h00C00040, 4'h0, 4'h0, 5);
    check("pullup_in", 8'(port_in_data), 8'h0F);
    // port outputs loop back through the pads
    drive(32'hFAC00040, 4'h0, 4'h0, 5);
    check("loopback", 8'(port_in_data), 8'h0A);
    // reset in mid-run drops the drivers at once; controls return on the second edge
    @(posedge clk);
    reset_n <= 1'b0;
    @(negedge clk);
    check("mid_rst_oe", 8'(pin_oe), 8'h00);
    @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check("rel_oe_1", 8'(pin_oe), 8'h00);
    check("rel_func_1", 8'(func), 8'(F_PORT_IN));
    @(posedge clk);
    @(negedge clk);
    check("rel_oe_2", 8'(pin_oe), 8'h0F);
    check("rel_out_2", 8'(pin_out), 8'h0A);
    check("rel_func_2", 8'(func), 8'(F_PORT_OUT));
    test_done();
  end
endmodule
